// File: design/rcv_regulator_control.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - software bit disables supply output regulator
// - software bit selects output regulator low power
// - read-only flag shows sense input level
// - enabled sense edges pulse interrupt, no pending
// - usb reset source: sense edges request reset
// - core regulator stays on in stop by default
// - cutoff bit: stop shuts core supply down
module rcv_regulator_control (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ctl_wr,
    input  wire logic [7:0]        ctl_wdata,
    output var  logic [7:0]        ctl_rdata,
    input  wire logic              bus_power_sense,
    input  wire logic              bus_power_irq_enable,
    input  wire logic              usb_reset_source_enable,
    input  wire logic              stop_mode_request,
    output var  rcv_pkg::rcv_reg_ctl_t reg_ctl,
    output var  logic              bus_power_irq,
    output var  logic              usb_reset_request,
    output var  logic              core_power_down,
    output var  logic              osc_suspend_allowed
);

    rcv_pkg::rcv_ctl_t  ctl_reg;
    rcv_pkg::rcv_ctl_t  ctl_next;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    rcv_pkg::rcv_reg_ctl_t reg_ctl_reg;
    rcv_pkg::rcv_reg_ctl_t reg_ctl_next;
    logic               irq_reg;
    logic               irq_next;
    logic               rst_req_reg;
    logic               rst_req_next;
    logic               pd_reg;
    logic               pd_next;
    logic [3:0]         settle_reg;
    logic [3:0]         settle_next;
    logic               osc_ok_reg;
    logic               osc_ok_next;
    logic               sense_level;
    logic               sense_edge;
    logic [7:0]         wr_clean;
    logic [3:0]         lp_age_reg;
    logic [3:0]         lp_age_next;

    // ****************************************************************
    // sense input synchroniser
    // ****************************************************************
    rcv_sync rcv_sync_i (
        .clk        (clk),
        .rst_b      (rst_b),
        .async_in   (bus_power_sense),
        .level      (sense_level),
        .edge_pulse (sense_edge)
    );

    // ****************************************************************
    // control byte
    // ****************************************************************
    // level bit masked off and reserved bits forced to zero on writes
    assign wr_clean = ctl_wdata & rcv_pkg::CTL_WRITE_MASK & ~rcv_pkg::CTL_MUST_ZERO;

    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_wr) begin
            ctl_next.ldo_out_disable          = wr_clean[rcv_pkg::CTL_BIT_OUT_DIS];
            ctl_next.ldo_out_lowpower_select  = wr_clean[rcv_pkg::CTL_BIT_OUT_LP];
            ctl_next.stop_core_supply_cutoff  = wr_clean[rcv_pkg::CTL_BIT_CUTOFF];
            ctl_next.core_ldo_lowpower_select = wr_clean[rcv_pkg::CTL_BIT_CORE_LP];
        end
        rdata_next = 8'h00;
        rdata_next[rcv_pkg::CTL_BIT_OUT_DIS] = ctl_next.ldo_out_disable;
        rdata_next[rcv_pkg::CTL_BIT_LEVEL]   = sense_level;
        rdata_next[rcv_pkg::CTL_BIT_OUT_LP]  = ctl_next.ldo_out_lowpower_select;
        rdata_next[rcv_pkg::CTL_BIT_CUTOFF]  = ctl_next.stop_core_supply_cutoff;
        rdata_next[rcv_pkg::CTL_BIT_CORE_LP] = ctl_next.core_ldo_lowpower_select;
    end

    // control byte registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_reg   <= rcv_pkg::rcv_ctl_t'(rcv_pkg::CTL_FIELDS_RESET);
            rdata_reg <= rcv_pkg::CTL_RESET;
        end else begin
            ctl_reg   <= ctl_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // regulator controls, events and stop handling
    // ****************************************************************
    always_comb begin
        reg_ctl_next.supply_output_enable   = !ctl_reg.ldo_out_disable;
        reg_ctl_next.supply_output_lowpower = ctl_reg.ldo_out_lowpower_select;
        reg_ctl_next.core_supply_lowpower   = ctl_reg.core_ldo_lowpower_select;
        reg_ctl_next.core_cutoff_armed      = ctl_reg.stop_core_supply_cutoff;
        irq_next     = sense_edge && bus_power_irq_enable;
        rst_req_next = sense_edge && usb_reset_source_enable;
        // core stays powered in stop unless cutoff is armed
        pd_next      = stop_mode_request && ctl_reg.stop_core_supply_cutoff;
        // settle count after core low power is chosen
        settle_next  = settle_reg;
        osc_ok_next  = 1'b0;
        if (!ctl_reg.core_ldo_lowpower_select) begin
            settle_next = 4'h0;
        end else if (settle_reg != 4'(rcv_pkg::CORE_LP_SETTLE)) begin
            settle_next = settle_reg + 4'h1;
        end
        // allow while core low power is off, or once a full settle span has already been counted
        if (!ctl_reg.core_ldo_lowpower_select || settle_reg == 4'(rcv_pkg::CORE_LP_SETTLE)) begin
            osc_ok_next = 1'b1;
        end
    end

    // regulator, event and stop registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_ctl_reg <= rcv_pkg::rcv_reg_ctl_t'(rcv_pkg::REG_CTL_RESET);
            irq_reg     <= 1'b0;
            rst_req_reg <= 1'b0;
            pd_reg      <= 1'b0;
            settle_reg  <= 4'h0;
            osc_ok_reg  <= 1'b1;
        end else begin
            reg_ctl_reg <= reg_ctl_next;
            irq_reg     <= irq_next;
            rst_req_reg <= rst_req_next;
            pd_reg      <= pd_next;
            settle_reg  <= settle_next;
            osc_ok_reg  <= osc_ok_next;
        end
    end

    assign ctl_rdata           = rdata_reg;
    assign reg_ctl             = reg_ctl_reg;
    assign bus_power_irq       = irq_reg;
    assign usb_reset_request   = rst_req_reg;
    assign core_power_down     = pd_reg;
    assign osc_suspend_allowed = osc_ok_reg;

    // ****************************************************************
    // settle watch for the assertions
    // ****************************************************************
    // cycles the core regulator has stayed in low power, saturating
    always_comb begin
        lp_age_next = 4'h0;
        if (reg_ctl_reg.core_supply_lowpower) begin
            lp_age_next = lp_age_reg;
            if (lp_age_reg != 4'hF) begin
                lp_age_next = lp_age_reg + 4'h1;
            end
        end
    end

    // settle watch register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lp_age_reg <= 4'h0;
        end else begin
            lp_age_reg <= lp_age_next;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_out_disable: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr && ctl_wdata[7] |=> ##1 !reg_ctl.supply_output_enable)
        else $error("output regulator not disabled");

    a_out_lowpower: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr |=> ##1 reg_ctl.supply_output_lowpower == $past(ctl_wdata[4], 2))
        else $error("low power select mismatch");

    a_level_flag: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 ctl_rdata[6] == $past(sense_level))
        else $error("level flag does not track sense");

    a_irq_edge: assert property (@(posedge clk) disable iff (!rst_b)
        bus_power_irq |-> $past(sense_edge) && $past(bus_power_irq_enable) ##1 !bus_power_irq)
        else $error("interrupt without enabled edge");

    a_usb_reset: assert property (@(posedge clk) disable iff (!rst_b)
        sense_edge && usb_reset_source_enable |=> usb_reset_request)
        else $error("edge missed as reset");

    a_core_kept: assert property (@(posedge clk) disable iff (!rst_b)
        !ctl_reg.stop_core_supply_cutoff |=> !core_power_down)
        else $error("core cut while not armed");

    a_core_cutoff: assert property (@(posedge clk) disable iff (!rst_b)
        stop_mode_request && ctl_reg.stop_core_supply_cutoff |=> core_power_down)
        else $error("cutoff not applied in stop");

    a_settle_wait: assert property (@(posedge clk) disable iff (!rst_b)
        reg_ctl.core_supply_lowpower && osc_suspend_allowed |-> lp_age_reg >= 4'(rcv_pkg::CORE_LP_SETTLE))
        else $error("oscillator suspend allowed too early");

    a_settle_release: assert property (@(posedge clk) disable iff (!rst_b)
        lp_age_reg >= 4'(rcv_pkg::CORE_LP_SETTLE) |-> osc_suspend_allowed)
        else $error("oscillator suspend still held after settle");

    a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_power_irq_enable |=> !bus_power_irq)
        else $error("interrupt while disabled");

    a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !usb_reset_source_enable |=> !usb_reset_request)
        else $error("reset request while not a source");

    a_flag_readonly: assert property (@(posedge clk) disable iff (!rst_b)
        ctl_wr && (ctl_wdata[6] != sense_level) |=> ctl_rdata[6] == $past(sense_level))
        else $error("level flag took a write");

endmodule

`default_nettype wire

// File: design/rcv_pkg.sv
package rcv_pkg;

    // ****************************************************************
    // reset values and field positions of the control byte
    // ****************************************************************
    localparam int        CTL_BIT_OUT_DIS   = 7;
    localparam int        CTL_BIT_LEVEL     = 6;
    localparam int        CTL_BIT_OUT_LP    = 4;
    localparam int        CTL_BIT_CUTOFF    = 3;
    localparam int        CTL_BIT_CORE_LP   = 1;
    localparam logic [7:0] CTL_RESET        = 8'h00;
    localparam logic [7:0] CTL_WRITE_MASK   = 8'hBF;  // level flag is read only
    localparam logic [7:0] CTL_MUST_ZERO    = 8'h25;  // reserved bits kept at zero
    localparam logic [3:0] CTL_FIELDS_RESET = 4'h0;   // stored control fields after reset
    localparam logic [3:0] REG_CTL_RESET    = 4'h8;   // output regulator enabled, rest off

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int        SYNC_STAGES       = 3;
    localparam int        CORE_LP_SETTLE    = 12;     // clocks before oscillator suspend

    // ****************************************************************
    // carried groups
    // ****************************************************************
    typedef struct packed {
        logic ldo_out_disable;
        logic ldo_out_lowpower_select;
        logic stop_core_supply_cutoff;
        logic core_ldo_lowpower_select;
    } rcv_ctl_t;

    typedef struct packed {
        logic supply_output_enable;
        logic supply_output_lowpower;
        logic core_supply_lowpower;
        logic core_cutoff_armed;
    } rcv_reg_ctl_t;

endpackage

// File: design/rcv_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage sense synchroniser with agreement filter and edge pulse
module rcv_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output var  logic level,
    output var  logic edge_pulse
);

    logic [rcv_pkg::SYNC_STAGES-1:0] sync_reg;
    logic [rcv_pkg::SYNC_STAGES-1:0] sync_next;
    logic                             level_reg;
    logic                             level_next;
    logic                             edge_reg;
    logic                             edge_next;

    // ****************************************************************
    // next state
    // ****************************************************************
    // level moves only when stages two and three agree
    always_comb begin
        sync_next  = {sync_reg[rcv_pkg::SYNC_STAGES-2:0], async_in};
        level_next = level_reg;
        edge_next  = 1'b0;
        if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
            level_next = sync_reg[2];
            edge_next  = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg  <= '0;
            level_reg <= 1'b0;
            edge_reg  <= 1'b0;
        end else begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
            edge_reg  <= edge_next;
        end
    end

    assign level      = level_reg;
    assign edge_pulse = edge_reg;

endmodule

`default_nettype wire

// File: dv/rcv_sense_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// bus power sense line
// ****************************************************************
module rcv_sense_model (
    input  wire logic attach,
    output var  logic bus_power_sense
);
    // pin follows the attach level after a skew, never on a clock edge
    initial bus_power_sense = 1'b0;
    always @(attach) begin
        bus_power_sense <= #1.3 attach;
    end
endmodule

`default_nettype wire

// File: dv/rcv_regulator_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module rcv_regulator_control_test;
    logic                  clk, rst_b, ctl_wr, irq_en, rst_en, stop_req, attach;
    logic [7:0]            ctl_wdata, ctl_rdata;
    logic                  sense, irq, usb_rst, core_pd, osc_ok;
    rcv_pkg::rcv_reg_ctl_t reg_ctl;
    int                    fails, checked, irq_n, rst_n, osc_low;

    // ****************************************************************
    // design, sense line and clock
    // ****************************************************************
    rcv_regulator_control rcv_regulator_control_i (
        .clk(clk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
        .ctl_rdata(ctl_rdata), .bus_power_sense(sense), .bus_power_irq_enable(irq_en),
        .usb_reset_source_enable(rst_en), .stop_mode_request(stop_req), .reg_ctl(reg_ctl),
        .bus_power_irq(irq), .usb_reset_request(usb_rst), .core_power_down(core_pd),
        .osc_suspend_allowed(osc_ok)
    );
    rcv_sense_model rcv_sense_model_i (.attach(attach), .bus_power_sense(sense));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // pulse and low-cycle counters, sampled once settled
    always @(posedge clk) begin
        #1;
        if (irq === 1'b1) irq_n++;
        if (usb_rst === 1'b1) rst_n++;
        if (osc_ok === 1'b0) osc_low++;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_ctl(input logic [7:0] v);
        @(posedge clk);
        ctl_wr    <= 1'b1;
        ctl_wdata <= v;
        @(posedge clk);
        ctl_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset;
        check("rdata", 8'h00, ctl_rdata);
        check("reg_ctl", 8'h08, {4'h0, reg_ctl});
        check("core_pd", 8'h00, {7'h00, core_pd});
        check("osc_ok", 8'h01, {7'h00, osc_ok});
        $display("test reset done");
    endtask

    task automatic test_bits;
        write_ctl(8'hF8);
        check("rdata", 8'h98, ctl_rdata);
        check("reg_ctl", 8'h05, {4'h0, reg_ctl});
        check("out_lp", 8'h01, {7'h00, reg_ctl.supply_output_lowpower});
        write_ctl(8'h00);
        check("reg_ctl", 8'h08, {4'h0, reg_ctl});
        $display("test bits done");
    endtask

    task automatic test_core_lp;
        osc_low = 0;
        write_ctl(8'h02);
        repeat (20) @(posedge clk);
        #1;
        check("osc_low", 8'h0C, 8'(osc_low));
        check("reg_ctl", 8'h0A, {4'h0, reg_ctl});
        write_ctl(8'h00);
        $display("test core low power done");
    endtask

    task automatic test_sense;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            irq_en <= i[0];
            rst_en <= i[1];
            attach <= ~attach;
            irq_n = 0;
            rst_n = 0;
            repeat (10) @(posedge clk);
            #1;
            check("irq_n", {7'h00, i[0]}, 8'(irq_n));
            check("rst_n", {7'h00, i[1]}, 8'(rst_n));
            check("level", {7'h00, attach}, {7'h00, ctl_rdata[6]});
        end
        $display("test sense done");
    endtask

    task automatic test_stop;
        @(posedge clk);
        stop_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("core_pd", 8'h00, {7'h00, core_pd});
        write_ctl(8'h08);
        check("core_pd", 8'h01, {7'h00, core_pd});
        @(posedge clk);
        stop_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("core_pd", 8'h00, {7'h00, core_pd});
        write_ctl(8'h00);
        $display("test stop done");
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        {rst_b, ctl_wr, irq_en, rst_en, stop_req, attach} = 6'h00;
        ctl_wdata = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        test_reset();
        test_bits();
        test_core_lp();
        test_sense();
        test_stop();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule

`default_nettype wire
